// [rtl/qct_params.svh]
/*
 * Constants for the four-channel counter/timer: control word field positions,
 * reset values and prescaler terminal counts.
 * Assumes it is included by bare name from the package and the design module.
 */
`ifndef QCT_PARAMS_SVH
`define QCT_PARAMS_SVH

// ************************************************************
// Control word fields
// ************************************************************
`define QCT_CW_CONTROL    0   // 1: control word, 0: vector byte
`define QCT_CW_SOFT_RESET 1   // Stop the channel
`define QCT_CW_TC_FOLLOWS 2   // Next write to this channel is the reload constant
`define QCT_CW_EXT_START  3   // Timer waits for a trigger edge before it runs
`define QCT_CW_RISING     4   // 1: rising trigger edge, 0: falling
`define QCT_CW_DIV256     5   // 1: prescale by 256, 0: by 16
`define QCT_CW_COUNTER    6   // 1: counter mode, 0: timer mode
`define QCT_CW_INT_EN     7   // Zero count raises an interrupt request

// ************************************************************
// Reset values and counts
// ************************************************************
`define QCT_CTRL_RESET    8'h00
`define QCT_TC_RESET      8'h00
`define QCT_VEC_RESET     5'h00
`define QCT_PRESC_END16   8'h0f
`define QCT_PRESC_END256  8'hff
`define QCT_NUM_CHAN      4
`define QCT_NUM_ZC        3

`endif

// [rtl/qct_pkg.sv]
/*
 * Types shared by the four-channel counter/timer design.
 * Assumes qct_params.svh is on the include path.
 */
`include "qct_params.svh"

package qct_pkg;

	// Channel run state, one-hot
	typedef enum logic [2:0] {
		QCT_IDLE      = 3'b001,
		QCT_WAIT_TRIG = 3'b010,
		QCT_RUN       = 3'b100
	} qct_state_t;

	// Everything one channel remembers
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] tconst;
		logic [7:0] count;
		logic [7:0] presc;
		logic       tc_follow;
		logic       pending;
		qct_state_t state;
	} qct_chan_t;

	// Host bus pins, active-high view after synchronising
	typedef struct packed {
		logic       ce;
		logic       iorq;
		logic       rd;
		logic       m1;
		logic [1:0] sel;
		logic [7:0] data;
	} qct_bus_t;

endpackage

// [rtl/qct_top.sv]
/*
 * Four-channel counter/timer with host port, per-channel prescaler,
 * auto-reloading down-counters, zero-count pulses and a vectored priority chain.
 * Assumes: one 10 MHz clock; all host and trigger pins are asynchronous and are
 * synchronised here, so host strobes must last several clock periods.
 */
`include "qct_params.svh"

module qct_top
	import qct_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        chip_enable_n,
	input  wire logic        io_request_n,
	input  wire logic        io_read_n,
	input  wire logic        machine_cycle_n,
	input  wire logic        channel_select_low,
	input  wire logic        channel_select_high,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	input  wire logic [3:0]  trigger_in,
	output logic      [2:0]  zero_count_pulse_out,
	output logic             interrupt_request_n,
	input  wire logic        priority_chain_in,
	output logic             priority_chain_out
);

	// ************************************************************
	// Functions
	// ************************************************************

	// Selected edge on a synchronised trigger
	function automatic logic trig_edge(input logic now, input logic prev, input logic rising);
		trig_edge = rising ? (now & ~prev) : (~now & prev);
	endfunction

	// Lowest-numbered pending channel wins
	function automatic logic [1:0] first_pending(input logic [3:0] pend);
		first_pending = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (pend[i]) begin
				first_pending = 2'(i);
			end
		end
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	qct_bus_t   bus_raw;
	qct_bus_t   bus_s1_r;
	qct_bus_t   bus_s2_r;
	logic [3:0] trig_s1_r;
	logic [3:0] trig_s2_r;
	logic [3:0] trig_d_r;
	logic       chain_s1_r;
	logic       chain_s2_r;

	// Select pins form the channel number, high select as msb
	assign bus_raw = '{ce: ~chip_enable_n, iorq: ~io_request_n, rd: ~io_read_n,
		m1: ~machine_cycle_n, sel: {channel_select_high, channel_select_low}, data: data_in};

	// Two stages on every pin; the third trigger stage only feeds edge detection
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bus_s1_r   <= '0;
			bus_s2_r   <= '0;
			trig_s1_r  <= 4'h0;
			trig_s2_r  <= 4'h0;
			trig_d_r   <= 4'h0;
			chain_s1_r <= 1'b0;
			chain_s2_r <= 1'b0;
		end else begin
			bus_s1_r   <= bus_raw;
			bus_s2_r   <= bus_s1_r;
			trig_s1_r  <= trigger_in;
			trig_s2_r  <= trig_s1_r;
			trig_d_r   <= trig_s2_r;
			chain_s1_r <= priority_chain_in;
			chain_s2_r <= chain_s1_r;
		end
	end

	// ************************************************************
	// Bus cycle decode
	// ************************************************************
	logic wr_act;
	logic rd_act;
	logic ack_act;

	assign wr_act  = bus_s2_r.ce & bus_s2_r.iorq & ~bus_s2_r.rd & ~bus_s2_r.m1;
	assign rd_act  = bus_s2_r.ce & bus_s2_r.iorq & bus_s2_r.rd & ~bus_s2_r.m1;
	assign ack_act = bus_s2_r.iorq & bus_s2_r.m1;

	// ************************************************************
	// Channel and output state
	// ************************************************************
	qct_chan_t  ch_r   [`QCT_NUM_CHAN];
	qct_chan_t  ch_nxt [`QCT_NUM_CHAN];
	logic [4:0] vec_hi_r;
	logic [4:0] vec_hi_nxt;
	logic       wr_prev_r;
	logic       ack_prev_r;
	logic [7:0] dout_r;
	logic [7:0] dout_nxt;
	logic       drive_r;
	logic       drive_nxt;
	logic [2:0] zc_r;
	logic [2:0] zc_nxt;
	logic [3:0] pend_vec;
	logic       wr_pulse;
	logic       ack_end;

	always_comb begin
		for (int i = 0; i < `QCT_NUM_CHAN; i++) begin
			pend_vec[i] = ch_r[i].pending;
		end
	end

	// A write acts once, on the first cycle the synchronised strobe is seen
	assign wr_pulse = wr_act & ~wr_prev_r;
	// Pending is retired when the acknowledge ends, after the vector was read
	assign ack_end  = ~ack_act & ack_prev_r & chain_s2_r & (|pend_vec);

	// Next state for every channel, the vector and the bus outputs
	always_comb begin
		logic tick;
		logic zero;
		logic edge_seen;
		logic [7:0] pend_end;
		logic [3:0] zero_all;
		tick      = 1'b0;
		zero      = 1'b0;
		edge_seen = 1'b0;
		pend_end  = `QCT_PRESC_END16;
		vec_hi_nxt = vec_hi_r;
		zero_all   = 4'h0;
		for (int i = 0; i < `QCT_NUM_CHAN; i++) begin
			ch_nxt[i] = ch_r[i];
			tick      = 1'b0;
			zero      = 1'b0;
			edge_seen = trig_edge(trig_s2_r[i], trig_d_r[i], ch_r[i].ctrl[`QCT_CW_RISING]);
			pend_end  = ch_r[i].ctrl[`QCT_CW_DIV256] ? `QCT_PRESC_END256 : `QCT_PRESC_END16;
			// Counting: prescaler in timer mode, trigger edges in counter mode
			case (ch_r[i].state)
				QCT_IDLE: begin
					ch_nxt[i].presc = 8'h00;
				end
				QCT_WAIT_TRIG: begin
					ch_nxt[i].presc = 8'h00;
					if (edge_seen) begin
						ch_nxt[i].state = QCT_RUN;
					end
				end
				QCT_RUN: begin
					if (ch_r[i].ctrl[`QCT_CW_COUNTER]) begin
						tick = edge_seen;
					end else if (ch_r[i].presc == pend_end) begin
						ch_nxt[i].presc = 8'h00;
						tick = 1'b1;
					end else begin
						ch_nxt[i].presc = ch_r[i].presc + 8'h01;
					end
				end
				default: begin
					ch_nxt[i].state = QCT_IDLE;
				end
			endcase
			// Count 1 is the last; a constant of 0 thus gives 256 steps
			if (tick) begin
				if (ch_r[i].count == 8'h01) begin
					zero = 1'b1;
					ch_nxt[i].count = ch_r[i].tconst;
				end else begin
					ch_nxt[i].count = ch_r[i].count - 8'h01;
				end
			end
			zero_all[i] = zero;
			// Clears come first so that a zero count in the same cycle still wins
			if (ack_end && first_pending(pend_vec) == 2'(i)) begin
				ch_nxt[i].pending = 1'b0;
			end
			// Host write to the selected channel only
			if (wr_pulse && bus_s2_r.sel == 2'(i)) begin
				if (ch_r[i].tc_follow) begin
					ch_nxt[i].tconst    = bus_s2_r.data;
					ch_nxt[i].tc_follow = 1'b0;
					// Running channels pick the new value up at the next zero
					if (ch_r[i].state == QCT_IDLE) begin
						ch_nxt[i].count = bus_s2_r.data;
						ch_nxt[i].state = (!ch_r[i].ctrl[`QCT_CW_COUNTER] && ch_r[i].ctrl[`QCT_CW_EXT_START])
							? QCT_WAIT_TRIG : QCT_RUN;
					end
				end else if (bus_s2_r.data[`QCT_CW_CONTROL]) begin
					ch_nxt[i].ctrl      = bus_s2_r.data;
					ch_nxt[i].tc_follow = bus_s2_r.data[`QCT_CW_TC_FOLLOWS];
					if (bus_s2_r.data[`QCT_CW_SOFT_RESET]) begin
						ch_nxt[i].state   = QCT_IDLE;
						ch_nxt[i].pending = 1'b0;
					end
					if (!bus_s2_r.data[`QCT_CW_INT_EN]) begin
						ch_nxt[i].pending = 1'b0;
					end
				end else if (i == 0) begin
					vec_hi_nxt = bus_s2_r.data[7:3];
				end
			end
			// Set last: a zero count beats a host clear in the same cycle
			if (zero && ch_r[i].ctrl[`QCT_CW_INT_EN]) begin
				ch_nxt[i].pending = 1'b1;
			end
		end
		// The last channel has no pulse pin, so its zero is dropped here
		zc_nxt = zero_all[`QCT_NUM_ZC-1:0];
		// Read port and acknowledge both drive data from flip-flops
		dout_nxt  = 8'h00;
		drive_nxt = 1'b0;
		if (rd_act) begin
			dout_nxt  = ch_r[bus_s2_r.sel].count;
			drive_nxt = 1'b1;
		end else if (ack_act && chain_s2_r && (|pend_vec)) begin
			dout_nxt  = {vec_hi_r, first_pending(pend_vec), 1'b0};
			drive_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `QCT_NUM_CHAN; i++) begin
				ch_r[i] <= '{ctrl: `QCT_CTRL_RESET, tconst: `QCT_TC_RESET, count: 8'h00,
					presc: 8'h00, tc_follow: 1'b0, pending: 1'b0, state: QCT_IDLE};
			end
			vec_hi_r   <= `QCT_VEC_RESET;
			wr_prev_r  <= 1'b0;
			ack_prev_r <= 1'b0;
			dout_r     <= 8'h00;
			drive_r    <= 1'b0;
			zc_r       <= 3'h0;
		end else begin
			for (int i = 0; i < `QCT_NUM_CHAN; i++) begin
				ch_r[i] <= ch_nxt[i];
			end
			vec_hi_r   <= vec_hi_nxt;
			wr_prev_r  <= wr_act;
			ack_prev_r <= ack_act;
			dout_r     <= dout_nxt;
			drive_r    <= drive_nxt;
			zc_r       <= zc_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign data_out             = dout_r;
	assign data_oe_n            = ~drive_r;
	assign zero_count_pulse_out = zc_r;
	// No in-service tracking: the chain opens again as soon as nothing is pending
	assign interrupt_request_n  = ~(|pend_vec);
	assign priority_chain_out   = chain_s2_r & ~(|pend_vec);

endmodule

// [tb/qct_top_checker.sv]
/* Pin-level assertions for the counter/timer.
   Assumes it is bound to qct_top, one clock, rst active high. */
module qct_top_checker (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       io_request_n,
	input wire logic       machine_cycle_n,
	input wire logic       priority_chain_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_n,
	input wire logic [2:0] zero_count_pulse_out,
	input wire logic       interrupt_request_n,
	input wire logic       priority_chain_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************
	// Assertions
	// ************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Host pins pass two sync flops, so a drive lags its request by three
	AST_DRIVE_NEEDS_REQ: assert property (!data_oe_n |-> $past(!io_request_n, 3))
		else $error("data driven without request");
	AST_IDLE_RELEASE: assert property (io_request_n [*4] |-> data_oe_n)
		else $error("data still driven");
	AST_QUIET_BUS: assert property (data_oe_n |-> data_out == 8'h00)
		else $error("data not zero");
	AST_ZC_PULSE: assert property (zero_count_pulse_out[0] |=> !zero_count_pulse_out[0])
		else $error("zero pulse too long");
	AST_CHAIN_BLOCK: assert property (!interrupt_request_n |-> !priority_chain_out)
		else $error("chain passed while pending");
	AST_CHAIN_IN: assert property (!priority_chain_in [*3] |-> !priority_chain_out)
		else $error("chain out without chain in");
	AST_VEC_EVEN: assert property ((!data_oe_n && $past(!machine_cycle_n, 3)) |-> !data_out[0])
		else $error("vector low bit set");
	AST_PEND_HOLD: assert property (io_request_n [*4] ##0 !interrupt_request_n |=> !interrupt_request_n)
		else $error("request dropped unserved");
endmodule

bind qct_top qct_top_checker chk_u (.clock(clock), .rst(rst), .io_request_n(io_request_n),
	.machine_cycle_n(machine_cycle_n), .priority_chain_in(priority_chain_in), .data_out(data_out),
	.data_oe_n(data_oe_n), .zero_count_pulse_out(zero_count_pulse_out),
	.interrupt_request_n(interrupt_request_n), .priority_chain_out(priority_chain_out));

// [tb/qct_host.sv]
/* Host processor bus model: write, read and acknowledge cycles.
   Assumes pins change at the falling clock edge and are held long enough to sync. */
module qct_host (
	input  wire logic       clock,
	input  wire logic [7:0] data_out,
	output logic            chip_enable_n,
	output logic            io_request_n,
	output logic            io_read_n,
	output logic            machine_cycle_n,
	output logic            channel_select_low,
	output logic            channel_select_high,
	output logic [7:0]      data_in,
	output logic            priority_chain_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************
	// Bus cycle
	// ************
	initial begin
		{chip_enable_n, io_request_n, io_read_n, machine_cycle_n} = 4'hf;
		{channel_select_high, channel_select_low} = 2'h0;
		data_in = 8'h00;
		priority_chain_in = 1'b1;
	end
	// Four clocks active and four idle: the syncs need at least three each
	task automatic cyc(input logic ce_n, rd_n, m1_n, input logic [1:0] ch, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clock);
		{chip_enable_n, io_request_n, io_read_n, machine_cycle_n} = {ce_n, 1'b0, rd_n, m1_n};
		{channel_select_high, channel_select_low} = ch;
		data_in = d;
		repeat (4) @(negedge clock);
		q = data_out;
		{chip_enable_n, io_request_n, io_read_n, machine_cycle_n} = 4'hf;
		data_in = ~d; // Released bus shows no stale byte
		repeat (4) @(negedge clock);
	endtask
endmodule

// [tb/tb_quad_counter_timer_channels.sv]
/* Self-checking bench for the counter/timer.
   Assumes qct_host drives the host pins and the bench drives triggers. */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb_quad_counter_timer_channels;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 0;
	logic       rst = 1;
	logic [3:0] trigger_in = 4'hf;
	wire        ce_n, iorq_n, rd_n, m1_n, csl, csh, oe_n, irq_n, ch_in, ch_out;
	wire  [7:0] din, dout;
	wire  [2:0] zc;
	int         bad_count, check_count, cycles, n;
	logic [7:0] q;
	// ************
	// Harness
	// ************
	always #50 clock = ~clock;
	qct_top dut_u (.clock(clock), .rst(rst), .chip_enable_n(ce_n), .io_request_n(iorq_n),
		.io_read_n(rd_n), .machine_cycle_n(m1_n), .channel_select_low(csl), .channel_select_high(csh),
		.data_in(din), .data_out(dout), .data_oe_n(oe_n), .trigger_in(trigger_in),
		.zero_count_pulse_out(zc), .interrupt_request_n(irq_n), .priority_chain_in(ch_in),
		.priority_chain_out(ch_out));
	qct_host host_u (.clock(clock), .data_out(dout), .chip_enable_n(ce_n), .io_request_n(iorq_n),
		.io_read_n(rd_n), .machine_cycle_n(m1_n), .channel_select_low(csl), .channel_select_high(csh),
		.data_in(din), .priority_chain_in(ch_in));
	task automatic wr(input logic [1:0] ch, input logic [7:0] d);
		logic [7:0] x;
		host_u.cyc(1'b0, 1'b1, 1'b1, ch, d, x);
	endtask
	// Cycles up to the next zero pulse of channel k
	task automatic zc_wait(input int k, output int c);
		c = 0;
		do begin @(posedge clock); #1 c++; end while (zc[k] !== 1'b1 && c < 5000);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard: whole run should need about 9000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin bad_count++; finish_test(); end
	end
	// ************
	// Scenarios
	// ************
	task automatic t_reset;
		`CHK({oe_n, irq_n, zc}, 5'h18)
		@(negedge clock) host_u.priority_chain_in = 1'b0;
		repeat (4) @(negedge clock);
		`CHK(ch_out, 1'b0)
		host_u.priority_chain_in = 1'b1;
		repeat (4) @(negedge clock);
		`CHK(ch_out, 1'b1)
	endtask
	// Control word then constant; period is prescale times constant, 0 meaning 256
	task automatic t_period;
		logic [7:0] cw[3] = '{8'h05, 8'h25, 8'h05};
		logic [7:0] tc[3] = '{8'h02, 8'h01, 8'h00};
		int         ex[3] = '{32, 256, 4096};
		for (int i = 0; i < 3; i++) begin wr(2'(i), cw[i]); wr(2'(i), tc[i]); end
		for (int i = 0; i < 3; i++) begin zc_wait(i, n); zc_wait(i, n); `CHK(n, ex[i]) end
	endtask
	task automatic t_reload;
		wr(2'h0, 8'h05);
		wr(2'h0, 8'h04);
		zc_wait(0, n); // No soft reset bit in 8'h05, so the channel keeps running and the first countdown still uses the old constant
		zc_wait(0, n);
		`CHK(n, 64)
	endtask
	// Counter mode on both trigger edges; read twice to show reads do not disturb
	task automatic t_count;
		for (int e = 0; e < 2; e++) begin
			@(negedge clock) trigger_in[3] = ~e[0];
			wr(2'h3, 8'h47 | (e[0] << 4));
			wr(2'h3, 8'h05);
			repeat (3) begin
				repeat (4) @(negedge clock) trigger_in[3] = e[0];
				repeat (4) @(negedge clock) trigger_in[3] = ~e[0];
			end
			host_u.cyc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, q);
			`CHK(q, 8'h02)
			host_u.cyc(1'b0, 1'b0, 1'b1, 2'h3, 8'h00, q);
			`CHK(q, 8'h02)
		end
	endtask
	task automatic t_irq;
		logic [7:0] on;
		wr(2'h0, 8'ha8);
		wr(2'h1, 8'h50);
		for (int c = 0; c < 2; c++) begin
			on = c ? 8'ha1 : 8'h81;
			wr(2'(c), on);
			n = 0;
			while (irq_n !== 1'b0 && n < 600) begin @(negedge clock); n++; end
			`CHK(irq_n, 1'b0)
			host_u.cyc(1'b1, 1'b1, 1'b0, 2'h0, 8'h00, q);
			`CHK(q, {5'h15, c[1:0], 1'b0})
			wr(2'(c), on & 8'h7f);
			`CHK(irq_n, 1'b1)
		end
	endtask
	// Timer held until a falling trigger edge; acknowledge refused with chain low, then granted
	task automatic t_trig;
		@(negedge clock) trigger_in[3] = 1'b1;
		wr(2'h3, 8'h8f);
		wr(2'h3, 8'h01);
		repeat (40) @(negedge clock);
		`CHK(irq_n, 1'b1)
		trigger_in[3] = 1'b0;
		repeat (10) @(negedge clock);
		`CHK(irq_n, 1'b1)
		repeat (14) @(negedge clock);
		`CHK(irq_n, 1'b0)
		host_u.priority_chain_in = 1'b0;
		repeat (4) @(negedge clock);
		host_u.cyc(1'b1, 1'b1, 1'b0, 2'h0, 8'h00, q);
		`CHK(q, 8'h00)
		`CHK(irq_n, 1'b0)
		host_u.priority_chain_in = 1'b1;
		repeat (4) @(negedge clock);
		host_u.cyc(1'b1, 1'b1, 1'b0, 2'h0, 8'h00, q);
		`CHK(q, 8'hae)
		// Second stop write clears a pending bit set by a zero that met the first
		wr(2'h3, 8'h03);
		wr(2'h3, 8'h03);
		`CHK(irq_n, 1'b1)
	endtask
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset();
		t_period();
		t_reload();
		t_count();
		t_irq();
		t_trig();
		finish_test();
	end
endmodule
